// ==== design/dswr_requests.sv ====
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Source request register: request bits 2:0, write-only enables 10:8.
// RQ2 - Source request bit changes only with its enable and enabled channel.
// RQ3 - Destination request register: request bits 2:0, enables 10:8.
// RQ4 - Destination request bit updates only with enable and enabled channel.
// RQ5 - Single source register: request bits 2:0, write-only enables 10:8.
// RQ6 - Single source bit written only with its enable and enabled channel.
// RQ7 - Single/burst destination register: request bits 2:0, enables 10:8.
// RQ8 - Single/burst destination bit updates only with enable, live channel.
// RQ9 - Final source bit high marks the last transaction of the block.
// RQ10 - Final source register has write-only enables 10:8 guarding each bit.
// RQ11 - Upper combined interrupt status word is read-only, reads zero.
// RQ12 - Hardware clears a channel enable after its last destination transfer.
// RQ13 - All channel enables are zero while the global enable is low.
// RQ14 - Final source bits use the same enable and channel gating.
// RQ15 - Enable fields and reserved bits read zero; reserved writes ignored.
module dswr_requests (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_hsel,
  input  wire logic [dswr_pkg::ADDR_W-1:0] i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic                      i_hready,
  input  wire logic [dswr_pkg::DATA_W-1:0] i_hwdata,
  output logic      [dswr_pkg::DATA_W-1:0] o_hrdata,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  input  wire logic                      i_dma_en,
  input  wire dswr_pkg::dswr_chan_t      i_chan_en_set,
  input  wire dswr_pkg::dswr_chan_t      i_chan_last_done,
  input  wire dswr_pkg::dswr_chan_t      i_req_serviced,
  output dswr_pkg::dswr_chan_t           o_chan_en,
  output dswr_pkg::dswr_chan_t           o_src_req,
  output dswr_pkg::dswr_chan_t           o_dst_req,
  output dswr_pkg::dswr_chan_t           o_src_single_req,
  output dswr_pkg::dswr_chan_t           o_dst_single_burst_req,
  output dswr_pkg::dswr_chan_t           o_src_final_request
);
  import dswr_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [GRP_W-1:0] grp_of(input logic [OFS_W-1:0] ofs);
    logic [GRP_W-1:0] g;
    g = GRP_NONE;
    case (ofs)
      OFS_SRC_SWREQ_LO:       g = GRP_SRC;
      OFS_DST_SWREQ_LO:       g = GRP_DST;
      OFS_SRC_SINGLE_REQ_LO:  g = GRP_SRC_SINGLE;
      OFS_DST_SB_REQ_LO:      g = GRP_DST_SB;
      OFS_SRC_FINAL_REQ_LO:   g = GRP_SRC_FINAL;
      OFS_COMB_IRQ_STATUS_HI,
      OFS_SRC_SWREQ_HI,
      OFS_DST_SWREQ_HI,
      OFS_SRC_SINGLE_REQ_HI,
      OFS_DST_SB_REQ_HI,
      OFS_SRC_FINAL_REQ_HI:   g = GRP_RSVD;
      default:                g = GRP_NONE;
    endcase
    return g;
  endfunction

  logic                 addr_phase;
  logic [GRP_W-1:0]     addr_grp;
  logic                 wr_pend;
  logic [GRP_W-1:0]     wr_grp;
  dswr_chan_t           chan_en;
  dswr_chan_t           req_q [NUM_GRP];
  dswr_chan_t           wr_data;
  dswr_chan_t           wr_mask;

  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign addr_grp   = grp_of(i_haddr[OFS_W-1:0]);
  assign wr_data    = i_hwdata[REQ_LSB +: NUM_CHAN];
  // A write only moves a bit whose enable rides in the same write and whose
  // channel is live
  assign wr_mask    = i_hwdata[WEN_LSB +: NUM_CHAN] & chan_en;

  // ****************************************************************
  // Bus slave: address phase capture, zero wait states
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_pend <= 1'b0;
      wr_grp  <= GRP_NONE;
    end else begin
      wr_pend <= addr_phase && i_hwrite;
      wr_grp  <= addr_grp;
    end
  end

  // Read data is sampled at the address phase, so a read that directly
  // follows a write to the same register returns the value before it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_hrdata <= RDATA_ZERO;
    end else if (addr_phase && !i_hwrite) begin
      if (addr_grp < GRP_RSVD) begin
        o_hrdata <= {{(DATA_W-NUM_CHAN){1'b0}}, req_q[addr_grp]}; // RQ15
      end else begin
        o_hrdata <= RDATA_ZERO; // RQ11
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_hreadyout <= 1'b0;
      o_hresp     <= HRESP_OKAY;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= HRESP_OKAY;
    end
  end

  // ****************************************************************
  // Channel enables
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      chan_en <= CHAN_EN_RST;
    end else if (!i_dma_en) begin
      chan_en <= CHAN_EN_RST; // RQ13
    end else begin
      // A new enable wins over a completion in the same cycle
      chan_en <= i_chan_en_set | (chan_en & ~i_chan_last_done); // RQ12
    end
  end
  assign o_chan_en = chan_en;

  // ****************************************************************
  // Request registers, one per group
  // ****************************************************************
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_req
    logic hit;
    assign hit = wr_pend && (wr_grp == GRP_W'(g));
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        req_q[g] <= REQ_RST;
      end else if (hit) begin
        // Software write beats a service clear on the bits it touches
        req_q[g] <= (req_q[g] & ~wr_mask & ~i_req_serviced)
                  | (wr_data & wr_mask); // RQ2 RQ4 RQ6 RQ8 RQ14
      end else begin
        req_q[g] <= req_q[g] & ~i_req_serviced;
      end
    end
  end

  assign o_src_req              = req_q[GRP_SRC]; // RQ1
  assign o_dst_req              = req_q[GRP_DST]; // RQ3
  assign o_src_single_req       = req_q[GRP_SRC_SINGLE]; // RQ5
  assign o_dst_single_burst_req = req_q[GRP_DST_SB]; // RQ7
  assign o_src_final_request    = req_q[GRP_SRC_FINAL]; // RQ9 RQ10

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_wr(logic [GRP_W-1:0] grp);
    addr_phase && i_hwrite && addr_grp == grp ##1 1'b1;
  endsequence

  sequence s_rd(logic [GRP_W-1:0] grp);
    addr_phase && !i_hwrite && addr_grp == grp;
  endsequence

  sequence s_no_svc;
    i_req_serviced == 3'h0;
  endsequence

  // Write whose data edge finds every channel off and no service clear
  sequence s_blk(logic [GRP_W-1:0] grp);
    s_wr(grp) ##0 o_chan_en == 3'h0 ##0 s_no_svc;
  endsequence

  property p_src_upd;
    s_wr(GRP_SRC) |=>
      ((o_src_req ^ $past(wr_data)) & $past(wr_mask)) == 3'h0;
  endproperty
  a_src_upd: assert property (p_src_upd) // RQ2
    else $error("source request not written");

  property p_src_hold;
    s_wr(GRP_SRC) ##0 (i_req_serviced == 3'h0) |=>
      ((o_src_req ^ $past(o_src_req)) & ~$past(wr_mask)) == 3'h0;
  endproperty
  a_src_hold: assert property (p_src_hold) // RQ2
    else $error("source request changed without enable");

  property p_dst_upd;
    s_wr(GRP_DST) |=>
      ((o_dst_req ^ $past(wr_data)) & $past(wr_mask)) == 3'h0;
  endproperty
  a_dst_upd: assert property (p_dst_upd) // RQ4
    else $error("destination request not written");

  property p_dst_blocked;
    s_wr(GRP_DST) ##0 (o_chan_en == 3'h0) ##0 (i_req_serviced == 3'h0)
      |=> $stable(o_dst_req);
  endproperty
  a_dst_blocked: assert property (p_dst_blocked) // RQ4
    else $error("destination request written on idle channel");

  property p_ssrc_upd;
    s_wr(GRP_SRC_SINGLE) |=>
      ((o_src_single_req ^ $past(wr_data)) & $past(wr_mask)) == 3'h0;
  endproperty
  a_ssrc_upd: assert property (p_ssrc_upd) // RQ6
    else $error("single source request not written");

  property p_sb_upd;
    s_wr(GRP_DST_SB) |=>
      ((o_dst_single_burst_req ^ $past(wr_data)) & $past(wr_mask)) == 3'h0;
  endproperty
  a_sb_upd: assert property (p_sb_upd) // RQ8
    else $error("single or burst request not written");

  property p_final_upd;
    s_wr(GRP_SRC_FINAL) |=>
      ((o_src_final_request ^ $past(wr_data)) & $past(wr_mask)) == 3'h0;
  endproperty
  a_final_upd: assert property (p_final_upd) // RQ14
    else $error("final source request not written");

  property p_other_quiet;
    wr_pend && wr_grp != GRP_SRC_FINAL && i_req_serviced == 3'h0
      |=> $stable(o_src_final_request);
  endproperty
  a_other_quiet: assert property (p_other_quiet) // RQ10
    else $error("final source request moved by foreign write");

  property p_hi_zero;
    s_rd(GRP_RSVD) |=> o_hrdata == RDATA_ZERO;
  endproperty
  a_hi_zero: assert property (p_hi_zero) // RQ11
    else $error("reserved word read non-zero");

  property p_lo_read;
    s_rd(GRP_SRC_FINAL) |=>
      o_hrdata == {29'h0, $past(o_src_final_request)};
  endproperty
  a_lo_read: assert property (p_lo_read) // RQ15
    else $error("read-back shows enable or reserved bits");

  property p_global_off;
    !i_dma_en |=> o_chan_en == 3'h0 ##1 (!$past(i_dma_en) ||
      (o_chan_en & ~$past(i_chan_en_set)) == 3'h0);
  endproperty
  a_global_off: assert property (p_global_off) // RQ13
    else $error("channel enabled while global enable low");

  property p_done_clears;
    i_dma_en && (i_chan_last_done & ~i_chan_en_set) != 3'h0 |=>
      (o_chan_en & $past(i_chan_last_done & ~i_chan_en_set)) == 3'h0;
  endproperty
  a_done_clears: assert property (p_done_clears) // RQ12
    else $error("channel enable survived last transfer");

  property p_dst_hold;
    s_wr(GRP_DST) ##0 s_no_svc |=>
      ((o_dst_req ^ $past(o_dst_req)) & ~$past(wr_mask)) == 3'h0;
  endproperty
  a_dst_hold: assert property (p_dst_hold) // RQ4
    else $error("destination request changed without enable");

  property p_ssrc_hold;
    s_wr(GRP_SRC_SINGLE) ##0 s_no_svc |=>
      ((o_src_single_req ^ $past(o_src_single_req))
        & ~$past(wr_mask)) == 3'h0;
  endproperty
  a_ssrc_hold: assert property (p_ssrc_hold) // RQ6
    else $error("single source request changed without enable");

  property p_sb_hold;
    s_wr(GRP_DST_SB) ##0 s_no_svc |=>
      ((o_dst_single_burst_req ^ $past(o_dst_single_burst_req))
        & ~$past(wr_mask)) == 3'h0;
  endproperty
  a_sb_hold: assert property (p_sb_hold) // RQ8
    else $error("single or burst request changed without enable");

  property p_final_hold;
    s_wr(GRP_SRC_FINAL) ##0 s_no_svc |=>
      ((o_src_final_request ^ $past(o_src_final_request))
        & ~$past(wr_mask)) == 3'h0;
  endproperty
  a_final_hold: assert property (p_final_hold) // RQ10
    else $error("final source request changed without enable");

  property p_src_blocked;
    s_blk(GRP_SRC) |=> $stable(o_src_req);
  endproperty
  a_src_blocked: assert property (p_src_blocked) // RQ2
    else $error("source request written on idle channel");

  property p_ssrc_blocked;
    s_blk(GRP_SRC_SINGLE) |=> $stable(o_src_single_req);
  endproperty
  a_ssrc_blocked: assert property (p_ssrc_blocked) // RQ6
    else $error("single source request written on idle channel");

  property p_sb_blocked;
    s_blk(GRP_DST_SB) |=> $stable(o_dst_single_burst_req);
  endproperty
  a_sb_blocked: assert property (p_sb_blocked) // RQ8
    else $error("single or burst request written on idle channel");

  property p_final_blocked;
    s_blk(GRP_SRC_FINAL) |=> $stable(o_src_final_request);
  endproperty
  a_final_blocked: assert property (p_final_blocked) // RQ14
    else $error("final source request written on idle channel");

  property p_src_read;
    s_rd(GRP_SRC) |=> o_hrdata == {29'h0, $past(o_src_req)};
  endproperty
  a_src_read: assert property (p_src_read) // RQ1
    else $error("source request read-back wrong");

  property p_dst_read;
    s_rd(GRP_DST) |=> o_hrdata == {29'h0, $past(o_dst_req)};
  endproperty
  a_dst_read: assert property (p_dst_read) // RQ3
    else $error("destination request read-back wrong");

  property p_ssrc_read;
    s_rd(GRP_SRC_SINGLE) |=> o_hrdata == {29'h0, $past(o_src_single_req)};
  endproperty
  a_ssrc_read: assert property (p_ssrc_read) // RQ5
    else $error("single source request read-back wrong");

  property p_sb_read;
    s_rd(GRP_DST_SB) |=> o_hrdata == {29'h0, $past(o_dst_single_burst_req)};
  endproperty
  a_sb_read: assert property (p_sb_read) // RQ7
    else $error("single or burst request read-back wrong");

  // Reserved and unmapped words swallow writes without side effects
  property p_rsvd_quiet;
    wr_pend && wr_grp >= GRP_RSVD ##0 s_no_svc |=> $stable(o_src_req)
      && $stable(o_dst_req) && $stable(o_src_single_req)
      && $stable(o_dst_single_burst_req) && $stable(o_src_final_request);
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) // RQ15
    else $error("reserved write moved a request");

  property p_idle_quiet;
    !wr_pend ##0 s_no_svc |=> $stable(o_src_req) && $stable(o_dst_req)
      && $stable(o_src_single_req) && $stable(o_dst_single_burst_req)
      && $stable(o_src_final_request);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // RQ2
    else $error("request moved without a write");

endmodule

// ==== design/dswr_pkg.sv ====
package dswr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int          NUM_CHAN    = 3;
  localparam int          NUM_GRP     = 5;
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 32;
  localparam int          OFS_W       = 12;
  localparam int          GRP_W       = 3;

  // ****************************************************************
  // Register offsets from the controller base
  // ****************************************************************
  localparam logic [11:0] OFS_COMB_IRQ_STATUS_HI  = 12'h364;
  localparam logic [11:0] OFS_SRC_SWREQ_LO        = 12'h368;
  localparam logic [11:0] OFS_SRC_SWREQ_HI        = 12'h36c;
  localparam logic [11:0] OFS_DST_SWREQ_LO        = 12'h370;
  localparam logic [11:0] OFS_DST_SWREQ_HI        = 12'h374;
  localparam logic [11:0] OFS_SRC_SINGLE_REQ_LO   = 12'h378;
  localparam logic [11:0] OFS_SRC_SINGLE_REQ_HI   = 12'h37c;
  localparam logic [11:0] OFS_DST_SB_REQ_LO       = 12'h380;
  localparam logic [11:0] OFS_DST_SB_REQ_HI       = 12'h384;
  localparam logic [11:0] OFS_SRC_FINAL_REQ_LO    = 12'h388;
  localparam logic [11:0] OFS_SRC_FINAL_REQ_HI    = 12'h38c;

  // ****************************************************************
  // Field layout of every request register low word
  // ****************************************************************
  localparam int          REQ_LSB     = 0;
  localparam int          WEN_LSB     = 8;

  // ****************************************************************
  // Register groups, reset values and bus codes
  // ****************************************************************
  localparam logic [2:0]  GRP_SRC        = 3'h0;
  localparam logic [2:0]  GRP_DST        = 3'h1;
  localparam logic [2:0]  GRP_SRC_SINGLE = 3'h2;
  localparam logic [2:0]  GRP_DST_SB     = 3'h3;
  localparam logic [2:0]  GRP_SRC_FINAL  = 3'h4;
  localparam logic [2:0]  GRP_RSVD       = 3'h5;
  localparam logic [2:0]  GRP_NONE       = 3'h7;

  localparam logic [2:0]  REQ_RST     = 3'h0;
  localparam logic [2:0]  CHAN_EN_RST = 3'h0;
  localparam logic [31:0] RDATA_ZERO  = 32'h0;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic        HRESP_OKAY  = 1'h0;

  typedef logic [2:0] dswr_chan_t;

endpackage

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import dswr_pkg::*;

  // ****************************************************************
  // Signals, clock and design
  // ****************************************************************
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        dma_en = 1'b0;
  dswr_chan_t  chan_set = 3'h0;
  dswr_chan_t  chan_done = 3'h0;
  dswr_chan_t  serviced = 3'h0;
  dswr_chan_t  chan_en;
  dswr_chan_t  req_o [5];
  dswr_chan_t  req_m [5];
  dswr_chan_t  chan_m;
  int          bad_count = 0;
  int          checks_done = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  dswr_requests i_dut (
    .i_clk                  (clk),
    .i_sys_rst              (sys_rst),
    .i_hsel                 (hsel),
    .i_haddr                (haddr),
    .i_htrans               (htrans),
    .i_hwrite               (hwrite),
    .i_hready               (1'b1),
    .i_hwdata               (hwdata),
    .o_hrdata               (hrdata),
    .o_hreadyout            (hreadyout),
    .o_hresp                (hresp),
    .i_dma_en               (dma_en),
    .i_chan_en_set          (chan_set),
    .i_chan_last_done       (chan_done),
    .i_req_serviced         (serviced),
    .o_chan_en              (chan_en),
    .o_src_req              (req_o[0]),
    .o_dst_req              (req_o[1]),
    .o_src_single_req       (req_o[2]),
    .o_dst_single_burst_req (req_o[3]),
    .o_src_final_request    (req_o[4])
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [11:0] lo_ofs(input int g);
    return 12'h368 + 12'(8 * g);
  endfunction

  // Masked bits take the new value, the others keep theirs
  function automatic dswr_chan_t upd(input dswr_chan_t old,
                                     input dswr_chan_t val,
                                     input dswr_chan_t msk);
    return (old & ~msk) | (val & msk);
  endfunction

  // Zero wait states, so each access is address phase then data phase
  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    dswr_chan_t mask;
    @(posedge clk); #1;
    hsel = 1'b1; htrans = HTRANS_NSEQ; hwrite = 1'b1;
    haddr = {20'h0, ofs};
    @(posedge clk); #1;
    hsel = 1'b0; htrans = 2'h0; hwdata = d;
    @(posedge clk); #1;
    mask = d[10:8] & chan_m;
    for (int g = 0; g < 5; g++) begin
      if (ofs == lo_ofs(g)) begin
        req_m[g] = upd(req_m[g], d[2:0], mask);
      end
    end
  endtask

  task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
    @(posedge clk); #1;
    hsel = 1'b1; htrans = HTRANS_NSEQ; hwrite = 1'b0;
    haddr = {20'h0, ofs};
    @(posedge clk); #1;
    hsel = 1'b0; htrans = 2'h0;
    check(hrdata, exp, "read data");
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  // One-cycle pulse on the channel side inputs, model follows
  task automatic pulse(input dswr_chan_t s, input dswr_chan_t d,
                       input dswr_chan_t sv);
    @(posedge clk); #1;
    chan_set = s; chan_done = d; serviced = sv;
    @(posedge clk); #1;
    chan_set = 3'h0; chan_done = 3'h0; serviced = 3'h0;
    chan_m = dma_en ? (s | (chan_m & ~d)) : 3'h0;
    for (int g = 0; g < 5; g++) req_m[g] &= ~sv;
    check({29'h0, chan_en}, {29'h0, chan_m}, "channel enables");
  endtask

  task automatic all_regs();
    for (int g = 0; g < 5; g++) begin
      check({29'h0, req_o[g]}, {29'h0, req_m[g]}, "request port");
      rd(lo_ofs(g), {29'h0, req_m[g]});
      rd(lo_ofs(g) + 12'h4, 32'h0);
    end
    rd(OFS_COMB_IRQ_STATUS_HI, 32'h0);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    #100000;
    bad_count++;
    $display("unexpected at %0t: run did not end", $time);
    stop_test();
  end

  initial begin
    logic [31:0] d;
    void'($urandom(37));
    for (int g = 0; g < 5; g++) req_m[g] = 3'h0;
    chan_m = 3'h0;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    @(posedge clk); #1;
    check({31'h0, hreadyout}, 32'h1, "ready after reset");
    all_regs();
    $display("test reset values done");
    // Writes with every channel disabled must not land
    for (int g = 0; g < 5; g++) wr(lo_ofs(g), 32'hffff_ffff);
    pulse(3'h7, 3'h0, 3'h0);
    all_regs();
    dma_en = 1'b1;
    pulse(3'h5, 3'h0, 3'h0);
    // Enable without write-enable bits, then reserved and hi words
    for (int g = 0; g < 5; g++) begin
      wr(lo_ofs(g), 32'hffff_f8ff);
      wr(lo_ofs(g) + 12'h4, 32'hffff_ffff);
    end
    wr(OFS_COMB_IRQ_STATUS_HI, 32'hffff_ffff);
    rd(12'h3f0, 32'h0);
    all_regs();
    $display("test gating done");
    for (int i = 0; i < 80; i++) begin
      d = $urandom;
      if (d[31:29] == 3'h0) begin
        dma_en = d[28] | d[27];
        pulse(d[2:0], d[6:4], d[10:8]);
      end else begin
        wr(lo_ofs(int'(d[26:24]) % 5), d);
        if (d[23]) all_regs();
      end
    end
    dma_en = 1'b1;
    pulse(3'h7, 3'h0, 3'h0);
    for (int g = 0; g < 5; g++) wr(lo_ofs(g), 32'h0000_0707);
    all_regs();
    pulse(3'h0, 3'h2, 3'h4);
    all_regs();
    dma_en = 1'b0;
    pulse(3'h0, 3'h0, 3'h0);
    all_regs();
    $display("test random traffic done");
    // Requests left standing by the global disable must clear on reset
    sys_rst = 1'h1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'h0;
    for (int g = 0; g < 5; g++) req_m[g] = 3'h0;
    chan_m = 3'h0;
    all_regs();
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
